/* verilog/twd_pkg.sv */
// Shared constants and types for the two-wire debug port
package twd_pkg;
   localparam int SYS_PERIOD_NS = 20;
   localparam int LINK_HALF_NS = 160;
   localparam int HALF_DIV = LINK_HALF_NS / SYS_PERIOD_NS;
   localparam int GAP_CYCLES = 2 * HALF_DIV;
   localparam int FIFO_W = 8;
   localparam int FIFO_D = 16;
   // Target addresses
   localparam logic [7:0] ADDR_PART = 8'h00;
   localparam logic [7:0] ADDR_REV = 8'h01;
   localparam logic [7:0] ADDR_UNLOCK = 8'h02;
   localparam logic [7:0] ADDR_DATA = 8'hbf;
   localparam logic [7:0] RST_BYTE = 8'h00;
   // Arbitrary identity values, not taken from any real part
   localparam logic [7:0] PART_ID_DEF = 8'h5a;
   localparam logic [7:0] REV_ID_DEF = 8'h11;
   localparam logic [7:0] UNLOCK_FIRST = 8'h02;
   localparam logic [7:0] UNLOCK_SECOND = 8'h01;
   localparam logic [7:0] CMD_BLK_RD = 8'h06;
   localparam logic [7:0] CMD_BLK_WR = 8'h07;
   localparam logic [7:0] CMD_PG_ERASE = 8'h08;
   localparam logic [7:0] CMD_DEV_ERASE = 8'h03;
   // Bit slots of a frame, counted in rising debug clock edges
   localparam logic [3:0] BIT_OP_LO = 4'h1;
   localparam logic [3:0] BIT_OP_HI = 4'h2;
   localparam logic [3:0] BIT_WDATA0 = 4'h3;
   localparam logic [3:0] BIT_WLAST = 4'ha;
   localparam logic [3:0] BIT_TURN = 4'h3;
   localparam logic [3:0] BIT_RDATA0 = 4'h4;
   localparam logic [3:0] BIT_LAST = 4'hb;
   typedef enum logic [1:0] {
      OP_ADDR_WR = 2'b00,
      OP_ADDR_RD = 2'b01,
      OP_DATA_WR = 2'b10,
      OP_DATA_RD = 2'b11
   } twd_op_t;
endpackage : twd_pkg

/* verilog/twd_link_if.sv */
// Two-pin debug link between programmer and target
`timescale 1ns/100ps
interface twd_link_if;
   logic debug_clock_pin;
   logic dd_host_o;
   logic dd_host_oe;
   logic dd_dev_o;
   logic dd_dev_oe;
   logic debug_data_pin;
   // Weak pull-down when nobody drives; host wins on contention
   assign debug_data_pin = dd_host_oe ? dd_host_o :
                           (dd_dev_oe ? dd_dev_o : 1'b0);
   modport host (output debug_clock_pin, output dd_host_o,
                 output dd_host_oe, input debug_data_pin);
   modport device (input debug_clock_pin, output dd_dev_o,
                   output dd_dev_oe, input debug_data_pin);
endinterface : twd_link_if

/* verilog/twd_device.sv */
// Target end of the debug port, feeding the flash byte stream
// Operation
// - Address 0x00 reads fixed part identifier.
// - Address 0x01 reads silicon revision code.
// - Writing 0x02 then 0x01 enables programming.
// - Programming stays enabled until system reset.
// - Data port carries flash bytes both ways.
// - Commands 0x06 block read, 0x07 block write.
// - Commands 0x08 page erase, 0x03 device erase.
// - Halt stalls peripherals and user software.
// - Debug port takes reset and data pins.
// - Target select steers data reads and writes.
`timescale 1ns/100ps
module twd_device import twd_pkg::*; (
   input wire logic clk_sys, // System clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic ce, // Clock enable
   twd_link_if.device link, // Debug pins
   output logic halt, // Stalls core and peripherals
   output logic prog_en, // Flash programming enabled
   output logic user_rst_n, // Reset pin level seen by user logic
   input wire logic user_dd_o, // User drive value for shared pin
   input wire logic user_dd_oe, // User drive enable for shared pin
   output logic user_dd_i, // Shared pin level seen by user logic
   output logic fl_valid, // Flash byte available
   input wire logic fl_ready, // Flash engine takes byte
   output logic [7:0] fl_data, // Flash byte
   output logic [3:0] fl_cmd, // Pulses: blk rd, blk wr, pg er, dev er
   input wire logic fl_done, // Flash operation finished
   input wire logic rd_valid, // Flash read byte strobe
   input wire logic [7:0] rd_data // Flash read byte
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_FRAME = 2'b10
   } twd_dst_t;

   twd_dst_t st_q;
   logic ck_s1, ck_s2, ck_s3;
   logic dd_s1, dd_s2;
   logic rise, fall;
   logic [3:0] cnt_q;
   logic [3:0] nxt;
   twd_op_t op_q;
   logic [7:0] sh_q;
   logic [7:0] byte_in;
   logic [7:0] tx_q;
   logic [7:0] target_select_q;
   logic [7:0] unlock_ctl_q;
   logic first_ok_q;
   logic prog_en_q;
   logic halt_q;
   logic [7:0] data_q;
   logic expect_cmd_q;
   logic [3:0] cmd_q;
   logic ack_q;
   logic dd_o_q, dd_oe_q;
   logic wr_done;
   logic data_wr;
   logic push;
   logic fifo_in_ready;

   function automatic logic [7:0] rd_mux(input logic [7:0] sel,
                                         input logic [7:0] ulk,
                                         input logic [7:0] dat);
      case (sel)
         ADDR_PART: rd_mux = PART_ID_DEF;
         ADDR_REV: rd_mux = REV_ID_DEF;
         ADDR_UNLOCK: rd_mux = ulk;
         ADDR_DATA: rd_mux = dat;
         default: rd_mux = 8'h00;
      endcase
   endfunction : rd_mux

   // Pins come from the programmer's domain
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         {ck_s1, ck_s2, ck_s3} <= 3'h7;
         {dd_s1, dd_s2} <= 2'h0;
      end else if (ce) begin
         ck_s1 <= link.debug_clock_pin;
         ck_s2 <= ck_s1;
         ck_s3 <= ck_s2;
         dd_s1 <= link.debug_data_pin;
         dd_s2 <= dd_s1;
      end
   end

   assign rise = ck_s2 && !ck_s3;
   assign fall = !ck_s2 && ck_s3;
   assign nxt = cnt_q + 4'h1;
   assign byte_in = {dd_s2, sh_q[7:1]};
   assign wr_done = rise && st_q == ST_FRAME && nxt == BIT_WLAST
                    && !op_q[0];
   assign data_wr = wr_done && op_q == OP_DATA_WR;
   assign push = data_wr && target_select_q == ADDR_DATA && prog_en_q
                 && fifo_in_ready;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st_q <= ST_IDLE;
         cnt_q <= 4'h0;
         op_q <= OP_ADDR_WR;
         sh_q <= RST_BYTE;
      end else if (ce && rise) begin
         case (st_q)
            ST_IDLE: begin
               if (dd_s2) begin
                  st_q <= ST_FRAME;
                  cnt_q <= 4'h0;
               end
            end
            ST_FRAME: begin
               cnt_q <= nxt;
               if (nxt == BIT_OP_LO) begin
                  op_q <= twd_op_t'({op_q[1], dd_s2});
               end
               if (nxt == BIT_OP_HI) begin
                  op_q <= twd_op_t'({dd_s2, op_q[0]});
               end
               sh_q <= byte_in;
               if (nxt == BIT_LAST) begin
                  st_q <= ST_IDLE;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // Address register selects the data target
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         target_select_q <= RST_BYTE;
      end else if (ce && wr_done && op_q == OP_ADDR_WR) begin
         target_select_q <= byte_in;
      end
   end

   // Any stray value drops the partial sequence
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         unlock_ctl_q <= RST_BYTE;
         first_ok_q <= 1'b0;
         prog_en_q <= 1'b0;
      end else if (ce && data_wr && target_select_q == ADDR_UNLOCK) begin
         unlock_ctl_q <= byte_in;
         first_ok_q <= (byte_in == UNLOCK_FIRST);
         if (first_ok_q && byte_in == UNLOCK_SECOND) begin
            prog_en_q <= 1'b1;
         end
      end
   end
   // Only rstn clears prog_en_q, so programming mode is sticky
   assign prog_en = prog_en_q;

   // Once any frame starts the part stays halted until reset
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         halt_q <= 1'b0;
      end else if (ce && rise && st_q == ST_IDLE && dd_s2) begin
         halt_q <= 1'b1;
      end
   end
   assign halt = halt_q || prog_en_q;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         data_q <= RST_BYTE;
      end else if (ce) begin
         if (data_wr && target_select_q == ADDR_DATA) begin
            data_q <= byte_in;
         end else if (rd_valid) begin
            data_q <= rd_data;
         end
      end
   end

   // First byte after a finished operation is taken as a command
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         expect_cmd_q <= 1'b1;
         cmd_q <= 4'h0;
      end else if (ce) begin
         cmd_q <= 4'h0;
         if (push && expect_cmd_q) begin
            case (byte_in)
               CMD_BLK_RD: cmd_q <= 4'h1;
               CMD_BLK_WR: cmd_q <= 4'h2;
               CMD_PG_ERASE: cmd_q <= 4'h4;
               CMD_DEV_ERASE: cmd_q <= 4'h8;
               default: cmd_q <= 4'h0;
            endcase
            expect_cmd_q <= !(byte_in == CMD_BLK_RD
                              || byte_in == CMD_BLK_WR
                              || byte_in == CMD_PG_ERASE
                              || byte_in == CMD_DEV_ERASE);
         end else if (fl_done) begin
            expect_cmd_q <= 1'b1;
         end
      end
   end
   assign fl_cmd = cmd_q;

   // Ack low tells the programmer a data byte was refused
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ack_q <= 1'b0;
         tx_q <= RST_BYTE;
      end else if (ce && rise && st_q == ST_FRAME) begin
         if (wr_done) begin
            ack_q <= !(op_q == OP_DATA_WR && target_select_q == ADDR_DATA)
                     || push;
         end
         if (nxt == BIT_TURN && op_q[0]) begin
            tx_q <= (op_q == OP_ADDR_RD) ? target_select_q :
                    rd_mux(target_select_q, unlock_ctl_q, data_q);
         end
      end
   end

   // Drive on falling edges so the programmer samples stable data
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         dd_o_q <= 1'b0;
         dd_oe_q <= 1'b0;
      end else if (ce) begin
         if (rise && nxt == BIT_LAST) begin
            dd_oe_q <= 1'b0;
         end else if (fall && st_q == ST_FRAME) begin
            if (!op_q[0] && cnt_q == BIT_WLAST) begin
               dd_oe_q <= 1'b1;
               dd_o_q <= ack_q;
            end else if (op_q[0] && cnt_q >= BIT_TURN) begin
               dd_oe_q <= 1'b1;
               dd_o_q <= tx_q[3'(cnt_q - BIT_TURN)];
            end
         end
      end
   end

   // While halted the port owns both shared pins
   assign link.dd_dev_oe = halt ? dd_oe_q : user_dd_oe;
   assign link.dd_dev_o = halt ? dd_o_q : user_dd_o;
   assign user_dd_i = halt ? 1'b0 : dd_s2;
   assign user_rst_n = halt ? 1'b1 : ck_s2;

   twd_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .ce(ce),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(byte_in),
      .out_valid(fl_valid),
      .out_ready(fl_ready),
      .out_data(fl_data)
   );
endmodule : twd_device

/* verilog/twd_host.sv */
// Programmer end of the debug link, and the target's byte FIFO
`timescale 1ns/100ps
module twd_host import twd_pkg::*; (
   input wire logic clk_sys, // System clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic ce, // Clock enable
   twd_link_if.host link, // Debug pins
   input wire logic req_valid, // Request
   output logic req_ready, // Host idle
   input wire logic [1:0] req_op, // Frame type
   input wire logic [7:0] req_data, // Address or data to write
   output logic rsp_valid, // Frame finished, one cycle
   output logic [7:0] rsp_data, // Byte read
   output logic rsp_ack // Write taken by target
);
   typedef enum logic [3:0] {
      HS_IDLE = 4'b0001,
      HS_LOW = 4'b0010,
      HS_HIGH = 4'b0100,
      HS_GAP = 4'b1000
   } twd_hst_t;

   twd_hst_t st_q;
   logic [7:0] div_q;
   logic [3:0] bit_q;
   twd_op_t op_q;
   logic [7:0] wd_q;
   logic [7:0] rd_q;
   logic ack_q;
   logic ck_q, o_q, oe_q;
   logic dd_s1, dd_s2;
   logic rsp_q;

   // Returns {oe, value} for one bit slot
   function automatic logic [1:0] slot(input twd_op_t op,
                                       input logic [7:0] d,
                                       input logic [3:0] idx);
      if (idx == 4'h0) begin
         slot = 2'b11;
      end else if (idx == BIT_OP_LO) begin
         slot = {1'b1, op[0]};
      end else if (idx == BIT_OP_HI) begin
         slot = {1'b1, op[1]};
      end else if (!op[0] && idx <= BIT_WLAST) begin
         slot = {1'b1, d[3'(idx - BIT_WDATA0)]};
      end else begin
         slot = 2'b00;
      end
   endfunction : slot

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         {dd_s1, dd_s2} <= 2'h0;
      end else if (ce) begin
         dd_s1 <= link.debug_data_pin;
         dd_s2 <= dd_s1;
      end
   end

   assign req_ready = (st_q == HS_IDLE);

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st_q <= HS_IDLE;
         div_q <= 8'h0;
         bit_q <= 4'h0;
         op_q <= OP_ADDR_WR;
         wd_q <= RST_BYTE;
         ck_q <= 1'b1;
         {oe_q, o_q} <= 2'b00;
         rsp_q <= 1'b0;
      end else if (ce) begin
         rsp_q <= 1'b0;
         div_q <= div_q + 8'h1;
         case (st_q)
            HS_IDLE: begin
               if (req_valid) begin
                  st_q <= HS_LOW;
                  op_q <= twd_op_t'(req_op);
                  wd_q <= req_data;
                  div_q <= 8'h0;
                  bit_q <= 4'h0;
                  ck_q <= 1'b0;
                  {oe_q, o_q} <= slot(twd_op_t'(req_op), req_data, 4'h0);
               end
            end
            HS_LOW: begin
               if (div_q == 8'(HALF_DIV - 1)) begin
                  st_q <= HS_HIGH;
                  div_q <= 8'h0;
                  ck_q <= 1'b1;
               end
            end
            HS_HIGH: begin
               if (div_q == 8'(HALF_DIV - 1)) begin
                  div_q <= 8'h0;
                  if (bit_q == BIT_LAST) begin
                     st_q <= HS_GAP;
                  end else begin
                     st_q <= HS_LOW;
                     bit_q <= bit_q + 4'h1;
                     ck_q <= 1'b0;
                     {oe_q, o_q} <= slot(op_q, wd_q, bit_q + 4'h1);
                  end
               end
            end
            HS_GAP: begin
               // Idle time lets the target release the data pin
               if (div_q == 8'(GAP_CYCLES - 1)) begin
                  st_q <= HS_IDLE;
                  rsp_q <= 1'b1;
               end
            end
            default: st_q <= HS_IDLE;
         endcase
      end
   end

   // Target bits are sampled just before each rising edge
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rd_q <= RST_BYTE;
         ack_q <= 1'b0;
      end else if (ce && st_q == HS_LOW && div_q == 8'(HALF_DIV - 1)) begin
         if (op_q[0] && bit_q >= BIT_RDATA0) begin
            rd_q <= {dd_s2, rd_q[7:1]};
         end
         if (!op_q[0] && bit_q == BIT_LAST) begin
            ack_q <= dd_s2;
         end
      end
   end

   assign link.debug_clock_pin = ck_q;
   assign link.dd_host_o = o_q;
   assign link.dd_host_oe = oe_q;
   assign rsp_valid = rsp_q;
   assign rsp_data = op_q[0] ? rd_q : 8'h00;
   assign rsp_ack = op_q[0] ? 1'b1 : ack_q;
endmodule : twd_host

module twd_fifo import twd_pkg::*; #(
   parameter int W = FIFO_W,
   parameter int D = FIFO_D
) (
   input wire logic clk_sys, // System clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic ce, // Clock enable
   input wire logic in_valid, // Write request
   output logic in_ready, // Not full
   input wire logic [W-1:0] in_data, // Write data
   output logic out_valid, // Not empty
   input wire logic out_ready, // Read acknowledge
   output logic [W-1:0] out_data // Head word
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != D[AW:0]);
   assign out_valid = (cnt_q != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rp_q];

   always_ff @(posedge clk_sys) begin
      if (ce && push) begin
         mem[wp_q] <= in_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else if (ce) begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule : twd_fifo

/* dv/twd_sva.sv */
// Concurrent checks on the two-pin debug link between the two ends
`timescale 1ns/100ps
module twd_sva (
   input wire logic clk_sys, // System clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic debug_clock_pin, // Link clock from the host
   input wire logic dd_host_o, // Host drive value
   input wire logic dd_host_oe, // Host drive enable
   input wire logic dd_dev_o, // Device drive value
   input wire logic dd_dev_oe, // Device drive enable
   input wire logic debug_data_pin // Resolved data wire
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   // Saturating count of high link clock cycles, for half period and gap
   logic [5:0] hi_cnt_q;
   always_ff @(posedge clk_sys) begin
      if (!rstn) hi_cnt_q <= 6'h00;
      else if (!debug_clock_pin) hi_cnt_q <= 6'h00;
      else if (hi_cnt_q != 6'h3f) hi_cnt_q <= hi_cnt_q + 6'h01;
   end
   property p_gap;
      $fell(debug_clock_pin) |-> (hi_cnt_q == 6'h08 || hi_cnt_q >= 6'h10);
   endproperty
   a_gap: assert property (p_gap)
      else $error("link clock high phase neither a half period nor a gap");
   property p_low_half;
      $fell(debug_clock_pin) |-> !debug_clock_pin [*8] ##1 debug_clock_pin;
   endproperty
   a_low_half: assert property (p_low_half)
      else $error("link clock low phase is not eight cycles");
   property p_high_half;
      $rose(debug_clock_pin) |-> debug_clock_pin [*8];
   endproperty
   a_high_half: assert property (p_high_half)
      else $error("link clock high phase shorter than eight cycles");
   property p_no_fight;
      !(dd_host_oe && dd_dev_oe);
   endproperty
   a_no_fight: assert property (p_no_fight)
      else $error("both ends drive the data wire");
   property p_idle_low;
      debug_clock_pin && hi_cnt_q >= 6'h10 |-> !debug_data_pin;
   endproperty
   a_idle_low: assert property (p_idle_low)
      else $error("data wire not released while the link is idle");
   property p_dev_hold;
      debug_clock_pin && $past(debug_clock_pin) && dd_dev_oe &&
         $past(dd_dev_oe) |-> $stable(dd_dev_o);
   endproperty
   a_dev_hold: assert property (p_dev_hold)
      else $error("device data changed while link clock high");
   property p_host_hold;
      debug_clock_pin && $past(debug_clock_pin) && dd_host_oe &&
         $past(dd_host_oe) |-> $stable(dd_host_o);
   endproperty
   a_host_hold: assert property (p_host_hold)
      else $error("host data changed while link clock high");
   property p_dev_start;
      $rose(dd_dev_oe) |-> !debug_clock_pin ##1 !debug_clock_pin;
   endproperty
   a_dev_start: assert property (p_dev_start)
      else $error("device took the wire outside a low clock phase");
   property p_dev_release;
      $fell(dd_dev_oe) |-> debug_clock_pin;
   endproperty
   a_dev_release: assert property (p_dev_release)
      else $error("device released the wire before the rising edge");
endmodule : twd_sva

/* dv/two_wire_debug_flash_regs_tb.sv */
// Self-checking bench joining host and device ends over the debug link
`timescale 1ns/100ps
module two_wire_debug_flash_regs_tb import twd_pkg::*; ();
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic req_valid = 1'b0;
   logic [1:0] req_op = 2'b00;
   logic [7:0] req_data = 8'h00;
   logic req_ready, rsp_valid, rsp_ack, ack;
   logic [7:0] rsp_data, fl_data, rd;
   logic halt, prog_en, user_rst_n, user_dd_i, fl_valid;
   logic fl_ready = 1'b0;
   logic fl_done = 1'b0;
   logic rd_valid = 1'b0;
   logic user_dd_o = 1'b0;
   logic user_dd_oe = 1'b0;
   logic [7:0] rd_data = 8'h00;
   logic [3:0] fl_cmd;
   logic [3:0] cmd_seen = 4'h0;
   int n_fail = 0;
   int n_tests = 0;
   twd_link_if lnk ();
   always #10 clk_sys = ~clk_sys;
   // Pulses are accumulated so that order is visible without clearing
   always @(posedge clk_sys) cmd_seen <= cmd_seen | fl_cmd;
   twd_host i_twd_host (.clk_sys(clk_sys), .rstn(rstn), .ce(1'b1),
      .link(lnk), .req_valid(req_valid), .req_ready(req_ready),
      .req_op(req_op), .req_data(req_data), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_ack(rsp_ack));
   twd_device i_twd_device (.clk_sys(clk_sys), .rstn(rstn), .ce(1'b1),
      .link(lnk), .halt(halt), .prog_en(prog_en), .user_rst_n(user_rst_n),
      .user_dd_o(user_dd_o), .user_dd_oe(user_dd_oe), .user_dd_i(user_dd_i),
      .fl_valid(fl_valid), .fl_ready(fl_ready), .fl_data(fl_data),
      .fl_cmd(fl_cmd), .fl_done(fl_done), .rd_valid(rd_valid),
      .rd_data(rd_data));
   twd_sva i_twd_sva (.clk_sys(clk_sys), .rstn(rstn),
      .debug_clock_pin(lnk.debug_clock_pin), .dd_host_o(lnk.dd_host_o),
      .dd_host_oe(lnk.dd_host_oe), .dd_dev_o(lnk.dd_dev_o),
      .dd_dev_oe(lnk.dd_dev_oe), .debug_data_pin(lnk.debug_data_pin));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : summarize
   // One frame: request held until taken, answer taken on the pulse
   task automatic xfer(input logic [1:0] op, input logic [7:0] d);
      int i;
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_op <= op;
      req_data <= d;
      i = 0;
      do begin
         @(posedge clk_sys);
         i++;
      end while (req_ready !== 1'b1 && i < 400);
      req_valid <= 1'b0;
      while (rsp_valid !== 1'b1 && i < 800) begin
         @(posedge clk_sys);
         i++;
      end
      if (i >= 800) n_fail++;
      rd = rsp_data;
      ack = rsp_ack;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(OP_ADDR_WR, a);
      xfer(OP_DATA_WR, d);
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      xfer(OP_ADDR_WR, a);
      xfer(OP_DATA_RD, 8'h00);
   endtask : rdr
   task automatic t_ids();
      check({7'h00, halt}, 8'h00);
      check({7'h00, user_rst_n}, 8'h01);
      rdr(ADDR_PART);
      check(rd, PART_ID_DEF);
      check({7'h00, halt}, 8'h01);
      // User logic asks for the shared pin; the halted port keeps it
      user_dd_oe <= 1'b1;
      user_dd_o <= 1'b1;
      repeat (3) @(posedge clk_sys);
      check({5'h00, user_rst_n, user_dd_i, lnk.dd_dev_oe}, 8'h04);
      user_dd_oe <= 1'b0;
      user_dd_o <= 1'b0;
      xfer(OP_DATA_WR, 8'hff);
      check({7'h00, ack}, 8'h01);
      xfer(OP_DATA_RD, 8'h00);
      check(rd, PART_ID_DEF);
      rdr(ADDR_REV);
      check(rd, REV_ID_DEF);
      xfer(OP_ADDR_RD, 8'h00);
      check(rd, ADDR_REV);
      rdr(8'h55);
      check(rd, 8'h00);
      $display("test ids done");
   endtask : t_ids
   task automatic t_unlock();
      logic [7:0] bad [4] = '{8'h01, 8'h02, 8'h05, 8'h01};
      wr(ADDR_DATA, 8'h11);
      check({7'h00, ack}, 8'h00);
      xfer(OP_ADDR_WR, ADDR_UNLOCK);
      for (int k = 0; k < 4; k++) begin
         xfer(OP_DATA_WR, bad[k]);
         check({7'h00, prog_en}, 8'h00);
      end
      xfer(OP_DATA_WR, UNLOCK_FIRST);
      check({7'h00, prog_en}, 8'h00);
      xfer(OP_DATA_WR, UNLOCK_SECOND);
      check({7'h00, prog_en}, 8'h01);
      $display("test unlock done");
   endtask : t_unlock
   task automatic t_stream();
      logic [7:0] exp [16];
      int n;
      int i;
      exp[0] = CMD_BLK_RD;
      exp[1] = CMD_BLK_WR;
      exp[2] = CMD_PG_ERASE;
      exp[3] = CMD_DEV_ERASE;
      xfer(OP_ADDR_WR, ADDR_DATA);
      for (int k = 0; k < 4; k++) begin
         xfer(OP_DATA_WR, exp[k]);
         check({7'h00, ack}, 8'h01);
         repeat (2) @(posedge clk_sys);
         check({4'h0, cmd_seen}, (8'h02 << k) - 8'h01);
         if (k < 3) begin
            fl_done <= 1'b1;
            @(posedge clk_sys);
            fl_done <= 1'b0;
         end
      end
      // Fill to the brim with the flash side stalled
      for (int k = 4; k < 16; k++) begin
         exp[k] = 8'h20 + 8'(k);
         xfer(OP_DATA_WR, exp[k]);
         check({7'h00, ack}, 8'h01);
      end
      xfer(OP_DATA_WR, 8'h99);
      check({7'h00, ack}, 8'h00);
      check({4'h0, cmd_seen}, 8'h0f);
      n = 0;
      i = 0;
      while (n < 16 && i < 200) begin
         @(posedge clk_sys);
         if (fl_ready === 1'b1 && fl_valid === 1'b1) begin
            check(fl_data, exp[n]);
            n++;
         end
         fl_ready <= (n < 16) && (i % 3 != 0);
         i++;
      end
      @(posedge clk_sys);
      check({7'h00, fl_valid}, 8'h00);
      check(8'(n), 8'h10);
      rd_valid <= 1'b1;
      rd_data <= 8'hc3;
      @(posedge clk_sys);
      rd_valid <= 1'b0;
      xfer(OP_DATA_RD, 8'h00);
      check(rd, 8'hc3);
      check({7'h00, prog_en}, 8'h01);
      $display("test stream done");
   endtask : t_stream
   task automatic t_reset();
      @(posedge clk_sys);
      rstn <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      check({6'h00, prog_en, halt}, 8'h00);
      repeat (20) @(posedge clk_sys);
      wr(ADDR_DATA, 8'h44);
      check({7'h00, ack}, 8'h00);
      $display("test reset done");
   endtask : t_reset
   initial begin
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (20) @(posedge clk_sys);
      t_ids();
      t_unlock();
      t_stream();
      t_reset();
      summarize();
   end
   initial begin
      #(40000 * 20);
      n_fail++;
      summarize();
   end
endmodule : two_wire_debug_flash_regs_tb
